//--- rtl/enc_cond_pkg.sv
// Package for the encoder signal conditioning block: register map, fields and timing.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus of 32-bit words.
package enc_cond_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_ANGLE   = 8'h04;
  localparam logic [7:0] OFF_WAIT    = 8'h08;
  localparam logic [7:0] OFF_WINDOW  = 8'h0C;
  localparam logic [7:0] OFF_ABZWAIT = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_IRQ     = 8'h18;
  localparam logic [7:0] OFF_MASK    = 8'h1C;

  // ==========================================================================
  // Configuration fields.
  localparam int CFG_ABZ_LSB   = 0;
  localparam int CFG_UVW_LSB   = 4;
  localparam int CFG_ZINV_BIT  = 7;
  localparam int CFG_RW_BIT    = 8;
  localparam int CFG_START_BIT = 9;

  // ==========================================================================
  // Interrupt sources.
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_READY   = 2;
  localparam int IRQ_W       = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Sequence tick timing.
  localparam int CLK_HZ      = 100_000_000;
  localparam int TICK_MS     = 2;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W      = 18;
  localparam int DLY_W       = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_MEASURE, ST_ABZWAIT, ST_RUN, ST_FAULT
  } seq_t;

endpackage : enc_cond_pkg

//--- rtl/encoder_signal_conditioning.sv
// Encoder input conditioning: channel inversion, A/B swap, commutation inversion and the
// power-up timing sequence of the reduced-wiring encoder, with a register slave on AHB-Lite.
// Assumes encoder pins are asynchronous and the AHB-Lite master issues single word transfers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] Conversion zero passes A, B, index unchanged.
// [RULE2] Bits 1,2,4 invert A, B, index.
// [RULE3] Settings 8-15 also swap A and B.
// [RULE4] Commutation setting bits invert U, V, W.
// [RULE5] Software keeps commutation inversion zero then.
// [RULE6] Software keeps conversion zero with index inversion.
// [RULE7] Reduced wiring: first A,B,index are U,V,W.
// [RULE8] Wait programmed start delay before sampling.
// [RULE9] Window end counted from measurement start.
// [RULE10] No capture in window raises timeout fault.
// [RULE11] Wait incremental delay before A/B/index control.
// [RULE12] Timer steps on 2 ms; delays even.
// [RULE13] Angle offsets rotor reference from index-to-U.
// [RULE14] Serial absolute: angle is index-to-zero difference.
// [RULE15] Sine encoder: angle is sine phase at index.
// [RULE16] Software picks direction from observed phase order.
// [RULE17] Index inversion applies before zero detection.
// [RULE18] Invert first, then swap, same sample.
module encoder_signal_conditioning (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        ENC_Z,
  input  wire logic        ENC_U,
  input  wire logic        ENC_V,
  input  wire logic        ENC_W,
  output logic             A_OUT,
  output logic             B_OUT,
  output logic             Z_OUT,
  output logic             U_OUT,
  output logic             V_OUT,
  output logic             W_OUT,
  output logic      [15:0] ROTOR_OFFSET,
  output logic             ABZ_CONTROL_ACTIVE,
  output logic             COMMUTATION_TIMEOUT_FAULT,
  output logic             IRQ
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [1:0]                       sync_a;
    logic [1:0]                       sync_b;
    logic [1:0]                       sync_z;
    logic [1:0]                       sync_u;
    logic [1:0]                       sync_v;
    logic [1:0]                       sync_w;
    logic [5:0]                       chan;
    logic [3:0]                       abz_conversion_select;
    logic [2:0]                       uvw_inversion_select;
    logic                             index_invert_select;
    logic                             reduced_wiring;
    logic                             seq_start;
    logic [15:0]                      index_to_u_angle;
    logic [enc_cond_pkg::DLY_W-1:0]   uvw_measure_wait;
    logic [enc_cond_pkg::DLY_W-1:0]   uvw_measure_window;
    logic [enc_cond_pkg::DLY_W-1:0]   abz_control_wait;
    enc_cond_pkg::seq_t               seq;
    logic [enc_cond_pkg::TICK_W-1:0]  prescale;
    logic [enc_cond_pkg::DLY_W-1:0]   elapsed;
    logic [2:0]                       uvw_latched;
    logic                             fault;
    logic [enc_cond_pkg::IRQ_W-1:0]   irq_status;
    logic [enc_cond_pkg::IRQ_W-1:0]   irq_mask;
    logic                             irq;
    logic                             dphase;
    logic                             dwrite;
    logic [7:0]                       daddr;
    logic [31:0]                      rdata;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = enc_cond_pkg::RST_ZERO;
    unique case (a)
      enc_cond_pkg::OFF_CONFIG:  r = {22'h000000, s.seq_start, s.reduced_wiring,
                                      s.index_invert_select, s.uvw_inversion_select,
                                      s.abz_conversion_select};
      enc_cond_pkg::OFF_ANGLE:   r = {16'h0000, s.index_to_u_angle};
      enc_cond_pkg::OFF_WAIT:    r = {16'h0000, s.uvw_measure_wait};
      enc_cond_pkg::OFF_WINDOW:  r = {16'h0000, s.uvw_measure_window};
      enc_cond_pkg::OFF_ABZWAIT: r = {16'h0000, s.abz_control_wait};
      enc_cond_pkg::OFF_STATUS:  r = {24'h000000, s.uvw_latched, s.fault, 1'b0, s.seq};
      enc_cond_pkg::OFF_IRQ:     r = {29'h00000000, s.irq_status};
      enc_cond_pkg::OFF_MASK:    r = {29'h00000000, s.irq_mask};
      default:                   r = enc_cond_pkg::RST_ZERO;
    endcase
    return r;
  endfunction

  logic       a_inv;
  logic       b_inv;
  logic       z_inv;
  logic [2:0] uvw_raw;
  logic [enc_cond_pkg::IRQ_W-1:0] ev;
  logic       tick;
  logic       take;

  always_comb begin
    d = q;
    ev = '0;
    // Synchronisers: only the second stage is read below.
    d.sync_a = {q.sync_a[0], ENC_A};
    d.sync_b = {q.sync_b[0], ENC_B};
    d.sync_z = {q.sync_z[0], ENC_Z};
    d.sync_u = {q.sync_u[0], ENC_U};
    d.sync_v = {q.sync_v[0], ENC_V};
    d.sync_w = {q.sync_w[0], ENC_W};

    // Inversion on the raw sample first, then the swap.
    a_inv = q.sync_a[1] ^ q.abz_conversion_select[0];                            // [RULE1] [RULE2]
    b_inv = q.sync_b[1] ^ q.abz_conversion_select[1];                            // [RULE2]
    z_inv = q.sync_z[1] ^ q.abz_conversion_select[2] ^ q.index_invert_select;    // [RULE17]
    d.chan[0] = q.abz_conversion_select[3] ? b_inv : a_inv;                      // [RULE3] [RULE18]
    d.chan[1] = q.abz_conversion_select[3] ? a_inv : b_inv;                      // [RULE3] [RULE18]
    d.chan[2] = z_inv;

    // Reduced wiring: commutation levels come over the A, B and index wires.
    uvw_raw = q.reduced_wiring ? {q.sync_z[1], q.sync_b[1], q.sync_a[1]}          // [RULE7]
                               : {q.sync_w[1], q.sync_v[1], q.sync_u[1]};
    d.chan[5:3] = (q.reduced_wiring ? q.uvw_latched : uvw_raw)
                  ^ q.uvw_inversion_select;                                       // [RULE4]

    // Sequence timer.
    tick = (q.prescale == enc_cond_pkg::TICK_W'(enc_cond_pkg::TICK_CYCLES - 1));
    d.prescale = tick ? '0 : q.prescale + 1'b1;                                  // [RULE12]
    if (tick) begin
      d.elapsed = q.elapsed + enc_cond_pkg::DLY_W'(enc_cond_pkg::TICK_MS);       // [RULE12]
    end
    unique case (q.seq)
      enc_cond_pkg::ST_IDLE: begin
        d.elapsed = '0;
        if (q.seq_start) begin
          d.seq = q.reduced_wiring ? enc_cond_pkg::ST_WAIT : enc_cond_pkg::ST_RUN;
          d.prescale = '0;
          ev[enc_cond_pkg::IRQ_READY] = !q.reduced_wiring;
        end
      end
      enc_cond_pkg::ST_WAIT: begin
        if (q.elapsed >= q.uvw_measure_wait) begin                               // [RULE8]
          d.seq = enc_cond_pkg::ST_MEASURE;
          d.elapsed = '0;
        end
      end
      enc_cond_pkg::ST_MEASURE: begin
        if (q.elapsed >= q.uvw_measure_window) begin                             // [RULE9]
          d.seq = enc_cond_pkg::ST_FAULT;
          d.fault = 1'b1;                                                        // [RULE10]
          ev[enc_cond_pkg::IRQ_TIMEOUT] = 1'b1;
        end else if (uvw_raw != 3'h0 && uvw_raw != 3'h7) begin
          // All-equal levels are not a valid commutation code, so they keep waiting.
          d.uvw_latched = uvw_raw;                                               // [RULE7]
          d.seq = enc_cond_pkg::ST_ABZWAIT;
          d.elapsed = '0;
          ev[enc_cond_pkg::IRQ_CAPTURE] = 1'b1;
        end
      end
      enc_cond_pkg::ST_ABZWAIT: begin
        if (q.elapsed >= q.abz_control_wait) begin                               // [RULE11]
          d.seq = enc_cond_pkg::ST_RUN;
          ev[enc_cond_pkg::IRQ_READY] = 1'b1;
        end
      end
      enc_cond_pkg::ST_RUN: begin
        if (!q.seq_start) begin
          d.seq = enc_cond_pkg::ST_IDLE;
        end
      end
      enc_cond_pkg::ST_FAULT: begin
        if (!q.seq_start) begin
          d.seq = enc_cond_pkg::ST_IDLE;
          d.fault = 1'b0;
        end
      end
      default: d.seq = enc_cond_pkg::ST_IDLE;
    endcase

    // AHB-Lite slave, zero wait states.
    take = HSEL && HREADY && HTRANS[1];
    if (q.dphase && q.dwrite) begin
      unique case (q.daddr)
        enc_cond_pkg::OFF_CONFIG: begin
          d.abz_conversion_select = HWDATA[enc_cond_pkg::CFG_ABZ_LSB +: 4];
          d.uvw_inversion_select  = HWDATA[enc_cond_pkg::CFG_UVW_LSB +: 3];
          d.index_invert_select   = HWDATA[enc_cond_pkg::CFG_ZINV_BIT];
          d.reduced_wiring        = HWDATA[enc_cond_pkg::CFG_RW_BIT];
          d.seq_start             = HWDATA[enc_cond_pkg::CFG_START_BIT];
        end
        enc_cond_pkg::OFF_ANGLE:   d.index_to_u_angle   = HWDATA[15:0];
        enc_cond_pkg::OFF_WAIT:    d.uvw_measure_wait   = HWDATA[15:0];
        enc_cond_pkg::OFF_WINDOW:  d.uvw_measure_window = HWDATA[15:0];
        enc_cond_pkg::OFF_ABZWAIT: d.abz_control_wait   = HWDATA[15:0];
        enc_cond_pkg::OFF_IRQ:     d.irq_status = q.irq_status & ~HWDATA[enc_cond_pkg::IRQ_W-1:0];
        enc_cond_pkg::OFF_MASK:    d.irq_mask   = HWDATA[enc_cond_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle.
    d.irq_status = d.irq_status | ev;
    d.irq = |(q.irq_status & q.irq_mask);
    d.dphase = take;
    d.dwrite = HWRITE;
    d.daddr = HADDR[7:0];
    d.rdata = (take && !HWRITE) ? read_mux(q, HADDR[7:0]) : enc_cond_pkg::RST_ZERO;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign A_OUT = q.chan[0];
  assign B_OUT = q.chan[1];
  assign Z_OUT = q.chan[2];
  assign U_OUT = q.chan[3];
  assign V_OUT = q.chan[4];
  assign W_OUT = q.chan[5];
  // The same angle serves commutation, serial absolute and sine encoders.
  assign ROTOR_OFFSET = q.index_to_u_angle;                                      // [RULE13] [RULE14] [RULE15]
  assign ABZ_CONTROL_ACTIVE = (q.seq == enc_cond_pkg::ST_RUN);
  assign COMMUTATION_TIMEOUT_FAULT = q.fault;                                    // [RULE10]
  assign IRQ = q.irq;
  assign HRDATA = q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

endmodule // encoder_signal_conditioning

`default_nettype wire

//--- verification/enc_cond_chk.sv
// Checker for the encoder conditioning block: pin paths, angle and sequence flags.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module enc_cond_chk (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        ENC_A,
  input wire logic        ENC_B,
  input wire logic        ENC_Z,
  input wire logic        ENC_U,
  input wire logic        A_OUT,
  input wire logic        B_OUT,
  input wire logic        Z_OUT,
  input wire logic        U_OUT,
  input wire logic [15:0] ROTOR_OFFSET,
  input wire logic        ABZ_CONTROL_ACTIVE,
  input wire logic        COMMUTATION_TIMEOUT_FAULT
);
  // ==========
  // Shadow of the written setup; pin and angle outputs are judged only once it has stood still a cycle.
  logic        wv_q;
  logic [7:0]  wa_q;
  logic [9:0]  cfg_q, cfgp_q;
  logic [15:0] ang_q, angp_q;
  logic [2:0]  n_q;
  wire         ok = n_q == 3'h7 && cfg_q == cfgp_q;
  always_ff @(posedge CLK_SYS) begin
    wv_q <= RSTN && HSEL && HREADY && HTRANS[1] && HWRITE;
    wa_q <= HADDR[7:0];
    cfgp_q <= cfg_q;
    angp_q <= ang_q;
    n_q <= !RSTN ? 3'h0 : n_q + {2'h0, n_q != 3'h7};
    if (!RSTN) begin
      cfg_q <= 10'h000;
      ang_q <= 16'h0000;
    end else if (wv_q && wa_q == enc_cond_pkg::OFF_CONFIG) begin
      cfg_q <= HWDATA[9:0];
    end else if (wv_q && wa_q == enc_cond_pkg::OFF_ANGLE) begin
      ang_q <= HWDATA[15:0];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_a_path: assert property (ok |-> A_OUT == (cfg_q[3] ?
    $past(ENC_B, 3) ^ cfg_q[1] : $past(ENC_A, 3) ^ cfg_q[0])) else $error("A output wrong");
  a_b_path: assert property (ok |-> B_OUT == (cfg_q[3] ?
    $past(ENC_A, 3) ^ cfg_q[0] : $past(ENC_B, 3) ^ cfg_q[1])) else $error("B output wrong");
  a_z_path: assert property (ok |-> Z_OUT == ($past(ENC_Z, 3) ^ cfg_q[2] ^ cfg_q[7]))
    else $error("index output wrong");
  a_u_path: assert property (ok && !cfg_q[8] |-> U_OUT == ($past(ENC_U, 3) ^ cfg_q[4]))
    else $error("U output wrong");
  a_angle_out: assert property (n_q == 3'h7 && ang_q == angp_q |-> ROTOR_OFFSET == ang_q)
    else $error("angle output wrong");
  a_fault_excl: assert property (COMMUTATION_TIMEOUT_FAULT |-> !ABZ_CONTROL_ACTIVE)
    else $error("fault and run together");
  a_run_start: assert property ($rose(ABZ_CONTROL_ACTIVE) |-> cfg_q[9])
    else $error("run without start");
  a_fault_cause: assert property ($rose(COMMUTATION_TIMEOUT_FAULT) |-> &cfg_q[9:8])
    else $error("fault outside reduced wiring");
  c_run: cover property ($rose(ABZ_CONTROL_ACTIVE));
  c_fault: cover property ($rose(COMMUTATION_TIMEOUT_FAULT));
  c_swap: cover property (ok && cfg_q[3]);
endmodule // enc_cond_chk
bind encoder_signal_conditioning enc_cond_chk chk (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HWDATA, .HREADY, .ENC_A, .ENC_B, .ENC_Z, .ENC_U, .A_OUT, .B_OUT, .Z_OUT, .U_OUT,
  .ROTOR_OFFSET, .ABZ_CONTROL_ACTIVE, .COMMUTATION_TIMEOUT_FAULT);
`default_nettype wire

//--- verification/quad_encoder_model.sv
// Behavioural incremental encoder with commutation track and reduced-wiring start levels.
// Assumes the bench steps it on the system clock through run.
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  input wire logic       clk,
  input wire logic       run,
  input wire logic       reduced,
  input wire logic [2:0] uvw_lvl,
  output logic           a,
  output logic           b,
  output logic           z,
  output logic           u,
  output logic           v,
  output logic           w
);
  // ==========
  // One count per clock while run is high, so the bench sets how far the shaft turns.
  logic [5:0] pos = 6'h00;
  always_ff @(posedge clk) pos <= pos + {5'h00, run};
  assign a = reduced ? uvw_lvl[0] : pos[1];
  assign b = reduced ? uvw_lvl[1] : pos[1] ^ pos[0];
  assign z = reduced ? uvw_lvl[2] : pos[5:2] == 4'h0;
  assign u = pos[5];
  assign v = pos[5] ^ pos[4];
  assign w = ~pos[4];
endmodule // quad_encoder_model
`default_nettype wire

//--- verification/encoder_signal_conditioning_bench.sv
// Self-checking bench: random setups through AHB-Lite, encoder model on the pins.
// Assumes the package is compiled first and the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module encoder_signal_conditioning_bench;
  logic CLK_SYS, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, run, red;
  logic ENC_A, ENC_B, ENC_Z, ENC_U, ENC_V, ENC_W, A_OUT, B_OUT, Z_OUT, U_OUT, V_OUT, W_OUT;
  logic ABZ_CONTROL_ACTIVE, COMMUTATION_TIMEOUT_FAULT;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, c, ang;
  logic [15:0] ROTOR_OFFSET;
  logic [2:0]  HSIZE, lvl;
  logic [1:0]  HTRANS;
  int          fail_count, checked;
  encoder_signal_conditioning uut (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
    .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .ENC_A, .ENC_B, .ENC_Z, .ENC_U,
    .ENC_V, .ENC_W, .A_OUT, .B_OUT, .Z_OUT, .U_OUT, .V_OUT, .W_OUT, .ROTOR_OFFSET,
    .ABZ_CONTROL_ACTIVE, .COMMUTATION_TIMEOUT_FAULT, .IRQ);
  quad_encoder_model enc (.clk(CLK_SYS), .run, .reduced(red), .uvw_lvl(lvl), .a(ENC_A),
    .b(ENC_B), .z(ENC_Z), .u(ENC_U), .v(ENC_V), .w(ENC_W));
  // ==========
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Entered just after a rising edge; read data is taken in the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h000000, a};
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do begin
      @(posedge CLK_SYS);
      rd = HRDATA;
    end while (HREADYOUT !== 1'b1);
  endtask
  task automatic wait_flag(input bit fault);
    for (int i = 0; i < 100 && (fault ? COMMUTATION_TIMEOUT_FAULT : ABZ_CONTROL_ACTIVE) !== 1'b1;
         i++) @(posedge CLK_SYS);
  endtask
  function automatic logic [2:0] exp_abz(input logic [31:0] s, input logic [2:0] p);
    logic [2:0] q;
    q = p ^ {s[2] ^ s[7], s[1:0]};
    return s[3] ? {q[2], q[0], q[1]} : q;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {HSEL, HWRITE, run, red, RSTN, HTRANS, lvl, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
    fail_count = 0;
    checked = 0;
    void'($urandom(79));
    repeat (2) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    for (int a = 0; a <= 32; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      cmp(rd, 32'h0, "reset value");
    end
    bus(1'b1, 8'h20, $urandom);
    bus(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 17; i++) begin
      c = 32'(i);
      c[6:4] = 3'($urandom_range(0, 7));
      if (i == 16) c = 32'h80;
      ang = $urandom;
      bus(1'b1, enc_cond_pkg::OFF_CONFIG, c);
      bus(1'b1, enc_cond_pkg::OFF_ANGLE, ang);
      run <= 1'b1;
      repeat ($urandom_range(1, 40)) @(posedge CLK_SYS);
      run <= 1'b0;
      repeat (5) @(posedge CLK_SYS);
      cmp(32'({Z_OUT, B_OUT, A_OUT}), 32'(exp_abz(c, {ENC_Z, ENC_B, ENC_A})), "abz");
      cmp(32'({W_OUT, V_OUT, U_OUT}), 32'({ENC_W, ENC_V, ENC_U} ^ c[6:4]), "uvw");
      cmp(32'(ROTOR_OFFSET), 32'(ang[15:0]), "angle");
    end
    $display("test conversion done");
    red <= 1'b1;
    lvl <= 3'($urandom_range(1, 6));
    c = 32'h300 | (32'($urandom_range(0, 7)) << 4);
    bus(1'b1, enc_cond_pkg::OFF_MASK, 32'h7);
    bus(1'b1, enc_cond_pkg::OFF_WINDOW, 32'h2);
    bus(1'b1, enc_cond_pkg::OFF_CONFIG, c);
    wait_flag(1'b0);
    cmp(32'(ABZ_CONTROL_ACTIVE), 32'h1, "run");
    cmp(32'({W_OUT, V_OUT, U_OUT}), 32'(lvl ^ c[6:4]), "latched uvw");
    bus(1'b0, enc_cond_pkg::OFF_STATUS, 32'h0);
    cmp(rd, 32'({lvl, 2'h0, enc_cond_pkg::ST_RUN}), "status");
    bus(1'b0, enc_cond_pkg::OFF_IRQ, 32'h0);
    cmp({IRQ, rd[30:0]}, 32'h8000_0005, "events");
    bus(1'b1, enc_cond_pkg::OFF_IRQ, 32'h7);
    bus(1'b1, enc_cond_pkg::OFF_CONFIG, 32'h0);
    cmp(32'(IRQ), 32'h0, "cleared");
    $display("test capture done");
    lvl <= 3'($urandom_range(0, 1) * 7);
    bus(1'b1, enc_cond_pkg::OFF_WINDOW, 32'h0);
    bus(1'b1, enc_cond_pkg::OFF_MASK, 32'h0);
    bus(1'b1, enc_cond_pkg::OFF_CONFIG, 32'h300);
    wait_flag(1'b1);
    cmp(32'({COMMUTATION_TIMEOUT_FAULT, ABZ_CONTROL_ACTIVE}), 32'h2, "timeout");
    bus(1'b0, enc_cond_pkg::OFF_STATUS, 32'h0);
    cmp(rd & 32'h1F, 32'h15, "fault status");
    bus(1'b0, enc_cond_pkg::OFF_IRQ, 32'h0);
    cmp({IRQ, rd[30:0]}, 32'h2, "masked");
    bus(1'b1, enc_cond_pkg::OFF_MASK, 32'h2);
    bus(1'b1, enc_cond_pkg::OFF_CONFIG, 32'h0);
    repeat (3) @(posedge CLK_SYS);
    cmp(32'({IRQ, COMMUTATION_TIMEOUT_FAULT}), 32'h2, "unmasked");
    $display("test timeout done");
    wrap_up();
  end
endmodule // encoder_signal_conditioning_bench
`default_nettype wire
